// ==== rtl/debug_breakpoint_pkg.sv ====
package debug_breakpoint_pkg;

   // Widths of the debug register port and core buses
   localparam int DATA_W = 32;
   localparam int CODE_W = 5;

   // Debug register codes seen on the register port
   localparam logic [4:0] CODE_CONFIG_STATUS = 5'h00;
   localparam logic [4:0] CODE_TRIGGER_DEF   = 5'h07;
   localparam logic [4:0] CODE_PC_ADDRESS    = 5'h08;
   localparam logic [4:0] CODE_PC_MASK       = 5'h09;
   localparam logic [4:0] CODE_DATA_VALUE    = 5'h0e;
   localparam logic [4:0] CODE_DATA_MASK     = 5'h0f;

   // Config/status field positions
   localparam int CSR_IGNORE_IRQ  = 5;
   localparam int CSR_SINGLE_STEP = 4;
   localparam int CSR_TRIG_HIT    = 24;
   localparam int CSR_HALTED      = 25;

   // Trigger definition field positions (first-level half)
   localparam int TDR_GLOBAL_EN = 13;
   localparam int TDR_LANE_HI   = 12;
   localparam int TDR_LANE_LO   = 6;
   localparam int TDR_PC_EN     = 1;

   // Data lane enable index within the seven-bit lane field
   localparam int LANE_LONG   = 6;
   localparam int LANE_WLOW   = 5;
   localparam int LANE_WUP    = 4;
   localparam int LANE_B_LL   = 3;
   localparam int LANE_B_LM   = 2;
   localparam int LANE_B_UM   = 1;
   localparam int LANE_B_UU   = 0;

   // Access size encoding on the core data bus
   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_WORD = 2'h1;
   localparam logic [1:0] SIZE_LONG = 2'h2;

   // Lane masks of the data bus
   localparam logic [31:0] MASK_B0   = 32'hff000000;
   localparam logic [31:0] MASK_B1   = 32'h00ff0000;
   localparam logic [31:0] MASK_B2   = 32'h0000ff00;
   localparam logic [31:0] MASK_B3   = 32'h000000ff;
   localparam logic [31:0] MASK_WUP  = 32'hffff0000;
   localparam logic [31:0] MASK_WLOW = 32'h0000ffff;
   localparam logic [31:0] MASK_LONG = 32'hffffffff;
   localparam logic [31:0] ZERO_WORD = 32'h00000000;

   // Step control states
   typedef enum logic [1:0] {ST_RUN, ST_HALTED, ST_STEP} step_state_t;

   // Register port request
   typedef struct packed {
      logic             wr;
      logic             rd;
      logic [4:0]       code;
      logic [31:0]      wdata;
   } reg_req_t;

   // One data bus reference from the core
   typedef struct packed {
      logic             valid;
      logic [1:0]       size;
      logic [1:0]       addr_lo;
      logic [31:0]      data;
   } data_ref_t;

endpackage : debug_breakpoint_pkg

// ==== rtl/debug_breakpoint_compare.sv ====
`timescale 1ns/100ps

// Summary of operation
// - Ignore flag drops interrupts raised during stepping
// - Ignore flag clear delivers interrupts raised stepping
// - Single-step bit halts after each instruction
// - Each resume in single-step mode runs exactly one instruction
// - Register commands accepted while halted
// - Data pattern compared against local data bus
// - Mask zero compares bit, one ignores
// - Compared lanes follow access size, address
// - Byte lane chosen by low address bits
// - Word by address bit one, longword full
// - Stored address compared with program counter
// - PC mask zero compares, one ignores
// - Global enable gates every breakpoint trigger
// - All lane enables clear disables data breaks
module debug_breakpoint_compare
   import debug_breakpoint_pkg::*;
(
   // Clock, reset, clock enable
   input  wire logic                           CLK,
   input  wire logic                           RST,
   input  wire logic                           CE,
   // Debug register port
   input  wire debug_breakpoint_pkg::reg_req_t REG_REQ,
   output logic [31:0]                         REG_RDATA,
   output logic                                REG_RVALID,
   // Core program counter
   input  wire logic                           PC_VALID,
   input  wire logic [31:0]                    PC,
   // Core local data bus
   input  wire debug_breakpoint_pkg::data_ref_t DATA_REF,
   // Core execution control
   input  wire logic                           INSN_DONE,
   input  wire logic                           GO_CMD,
   output logic                                HALT,
   // Interrupt gating
   input  wire logic                           IRQ_REQ,
   input  wire logic                           IRQ_ACK,
   output logic                                IRQ_TO_CORE,
   // Breakpoint results
   output logic                                PC_MATCH,
   output logic                                DATA_MATCH,
   output logic                                BREAK_TRIGGER
);

   import debug_breakpoint_pkg::*;

   // Whole state of the block
   typedef struct packed {
      step_state_t  step;          // Run / halted / stepping
      logic         ignore_irq;    // Drop interrupts raised while stepping
      logic         single_step;   // Halt after each instruction
      logic         trig_hit;      // Sticky trigger seen
      logic [31:0]  trigger_def;   // Trigger definition
      logic [31:0]  pc_addr;       // PC breakpoint address
      logic [31:0]  pc_mask;       // PC breakpoint mask
      logic [31:0]  data_value;    // Data breakpoint pattern
      logic [31:0]  data_mask;     // Data breakpoint mask
      logic         held_irq;      // Request raised during stepping
      logic [31:0]  rdata;         // Read answer
      logic         rvalid;        // Read answer strobe
      logic         halt;          // Halt to core
      logic         irq_out;       // Gated interrupt to core
      logic         pc_match;      // Registered PC hit
      logic         data_match;    // Registered data hit
      logic         trigger;       // Registered trigger
   } state_t;

   state_t cur;                    // Registered state
   state_t next_cur;               // Next state

   // Masked comparison shared by both comparators
   function automatic logic masked_equal(
      input logic [31:0] seen,
      input logic [31:0] pattern,
      input logic [31:0] mask
   );
      masked_equal = (((seen ^ pattern) & ~mask) == ZERO_WORD);
   endfunction : masked_equal

   // Lanes compared for one reference, zero when its lane is not enabled
   function automatic logic [31:0] lane_select(
      input logic [1:0] size,
      input logic [1:0] addr_lo,
      input logic [6:0] lanes
   );
      lane_select = ZERO_WORD;
      unique case (size)
         SIZE_BYTE: begin
            unique case (addr_lo)
               2'h0: lane_select = lanes[LANE_B_UU] ? MASK_B0 : ZERO_WORD;
               2'h1: lane_select = lanes[LANE_B_UM] ? MASK_B1 : ZERO_WORD;
               2'h2: lane_select = lanes[LANE_B_LM] ? MASK_B2 : ZERO_WORD;
               2'h3: lane_select = lanes[LANE_B_LL] ? MASK_B3 : ZERO_WORD;
            endcase
         end
         SIZE_WORD: begin
            if (addr_lo[1]) begin
               lane_select = lanes[LANE_WLOW] ? MASK_WLOW : ZERO_WORD;
            end else begin
               lane_select = lanes[LANE_WUP] ? MASK_WUP : ZERO_WORD;
            end
         end
         SIZE_LONG: begin
            lane_select = lanes[LANE_LONG] ? MASK_LONG : ZERO_WORD;
         end
         default: begin
            // Unused size code never matches
            lane_select = ZERO_WORD;
         end
      endcase
   endfunction : lane_select

   // Combinational helpers
   logic [6:0]  lane_en;           // Data lane enables
   logic [31:0] lane_bits;         // Bits in play for this reference
   logic        data_hit;          // Data comparator hit
   logic        pc_hit;            // PC comparator hit
   logic        global_en;         // Global breakpoint enable
   logic        trig_now;          // Trigger this cycle
   logic [31:0] status_word;       // Config/status read view
   logic        irq_any;           // Live or held request

   // Comparators and trigger
   always_comb begin
      lane_en   = cur.trigger_def[TDR_LANE_HI:TDR_LANE_LO];
      global_en = cur.trigger_def[TDR_GLOBAL_EN];
      // Aligned and misaligned references map to lanes by size and address
      lane_bits = lane_select(DATA_REF.size, DATA_REF.addr_lo, lane_en);
      // An empty lane set excludes the data comparator entirely
      data_hit  = DATA_REF.valid && (lane_en != 7'h00) && (lane_bits != ZERO_WORD)
                  && masked_equal(DATA_REF.data, cur.data_value, cur.data_mask | ~lane_bits);
      pc_hit    = PC_VALID && cur.trigger_def[TDR_PC_EN]
                  && masked_equal(PC, cur.pc_addr, cur.pc_mask);
      trig_now  = global_en && (pc_hit || data_hit);
      status_word = ZERO_WORD;
      status_word[CSR_IGNORE_IRQ]  = cur.ignore_irq;
      status_word[CSR_SINGLE_STEP] = cur.single_step;
      status_word[CSR_TRIG_HIT]    = cur.trig_hit;
      status_word[CSR_HALTED]      = (cur.step == ST_HALTED);
      irq_any = IRQ_REQ || cur.held_irq;
   end

   // Next-state logic
   always_comb begin
      next_cur = cur;
      next_cur.rvalid = 1'b0;
      // Register writes are taken in every step state, halted included
      if (REG_REQ.wr) begin
         unique case (REG_REQ.code)
            CODE_CONFIG_STATUS: begin
               next_cur.ignore_irq  = REG_REQ.wdata[CSR_IGNORE_IRQ];
               next_cur.single_step = REG_REQ.wdata[CSR_SINGLE_STEP];
            end
            CODE_TRIGGER_DEF: begin
               next_cur.trigger_def = REG_REQ.wdata;
               // Writing the trigger definition clears trigger status
               next_cur.trig_hit    = 1'b0;
            end
            CODE_PC_ADDRESS: next_cur.pc_addr    = REG_REQ.wdata;
            CODE_PC_MASK:    next_cur.pc_mask    = REG_REQ.wdata;
            CODE_DATA_VALUE: next_cur.data_value = REG_REQ.wdata;
            CODE_DATA_MASK:  next_cur.data_mask  = REG_REQ.wdata;
            default: begin
               // Unknown codes are ignored
               next_cur.trig_hit = next_cur.trig_hit;
            end
         endcase
      end
      // Reads answer one cycle later; write-only and unknown codes read zero
      if (REG_REQ.rd) begin
         next_cur.rvalid = 1'b1;
         unique case (REG_REQ.code)
            CODE_CONFIG_STATUS: next_cur.rdata = status_word;
            CODE_TRIGGER_DEF:   next_cur.rdata = cur.trigger_def;
            CODE_PC_MASK:       next_cur.rdata = cur.pc_mask;
            CODE_DATA_VALUE:    next_cur.rdata = cur.data_value;
            CODE_DATA_MASK:     next_cur.rdata = cur.data_mask;
            default:            next_cur.rdata = ZERO_WORD;
         endcase
      end
      // Trigger sticky bit: a hit wins over a clearing write
      if (trig_now) begin
         next_cur.trig_hit = 1'b1;
      end
      next_cur.pc_match   = pc_hit;
      next_cur.data_match = data_hit;
      next_cur.trigger    = trig_now;
      // Step control
      unique case (cur.step)
         ST_RUN: begin
            if (cur.single_step && INSN_DONE) begin
               next_cur.step = ST_HALTED;
            end
         end
         ST_HALTED: begin
            // Resume runs one instruction, or free-runs once stepping is off
            if (GO_CMD) begin
               next_cur.step = cur.single_step ? ST_STEP : ST_RUN;
            end
         end
         ST_STEP: begin
            if (INSN_DONE) begin
               next_cur.step = cur.single_step ? ST_HALTED : ST_RUN;
            end
         end
         default: begin
            // Unused state code falls back to free running
            next_cur.step = ST_RUN;
         end
      endcase
      next_cur.halt = (next_cur.step == ST_HALTED);
      // Requests raised while stepping are held; an ack clears, a new one wins
      if (IRQ_ACK) begin
         next_cur.held_irq = 1'b0;
      end
      if (cur.ignore_irq && !cur.single_step) begin
         // With ignore set, held requests are dropped once stepping ends
         next_cur.held_irq = 1'b0;
      end
      if (IRQ_REQ && cur.single_step) begin
         next_cur.held_irq = 1'b1;
      end
      // Never interrupt a halted core; stepping with ignore set masks all
      if (next_cur.step == ST_HALTED) begin
         next_cur.irq_out = 1'b0;
      end else if (cur.single_step && cur.ignore_irq) begin
         next_cur.irq_out = 1'b0;
      end else if (cur.ignore_irq) begin
         next_cur.irq_out = IRQ_REQ;
      end else begin
         next_cur.irq_out = irq_any && !IRQ_ACK;
      end
   end

   // State register, frozen while clock enable is low
   always_ff @(posedge CLK) begin
      if (RST) begin
         cur <= '0;
      end else if (CE) begin
         cur <= next_cur;
      end
   end

   // Outputs straight from the state register
   assign REG_RDATA     = cur.rdata;
   assign REG_RVALID    = cur.rvalid;
   assign HALT          = cur.halt;
   assign IRQ_TO_CORE   = cur.irq_out;
   assign PC_MATCH      = cur.pc_match;
   assign DATA_MATCH    = cur.data_match;
   assign BREAK_TRIGGER = cur.trigger;

endmodule : debug_breakpoint_compare

// ==== testbench/core_model.sv ====
`timescale 1ns/100ps
module core_model (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Pacing and status from the block
   input  wire logic [3:0] gap,
   input  wire logic       halt,
   input  wire logic       irq,
   // Pulses back to the block
   output logic            insn_done,
   output logic            irq_ack
);
   logic [3:0] cnt;  // Cycles left before the next retirement

   // Retire one instruction every gap plus one cycles while running; gap of two or more
   // keeps a second retirement from landing before a step halt shows
   always_ff @(posedge clk) begin
      if (rst || halt || insn_done) begin
         insn_done <= 1'b0;
         cnt       <= gap;
      end else if (cnt <= 4'h1) begin
         insn_done <= 1'b1;
      end else begin
         cnt <= cnt - 4'h1;
      end
   end

   // Take a delivered interrupt with a single acknowledge pulse
   always_ff @(posedge clk) begin
      irq_ack <= !rst && irq && !irq_ack;
   end
endmodule : core_model

// ==== testbench/debug_breakpoint_compare_asserts.sv ====
`timescale 1ns/100ps
module debug_breakpoint_compare_asserts
   import debug_breakpoint_pkg::*;
(
   // Clock and reset
   input wire logic                           CLK,
   input wire logic                           RST,
   // Register port and core side
   input wire debug_breakpoint_pkg::reg_req_t REG_REQ,
   input wire logic [31:0]                    REG_RDATA,
   input wire logic                           REG_RVALID,
   input wire logic                           PC_VALID,
   input wire logic [31:0]                    PC,
   input wire logic                           INSN_DONE,
   input wire logic                           GO_CMD,
   input wire logic                           HALT,
   input wire logic                           IRQ_TO_CORE,
   // Comparator results
   input wire logic                           PC_MATCH,
   input wire logic                           DATA_MATCH,
   input wire logic                           BREAK_TRIGGER
);
   logic [31:0] pa, pm, td;  // Shadows of the PC and trigger registers
   logic        pc_exp, gl;  // Expected PC hit and global enable, one cycle on

   // Shadow the registers from the write strobes; old values feed this edge's compare
   always_ff @(posedge CLK) begin
      if (RST) begin
         {pa, pm, td, pc_exp, gl} <= 98'h0;
      end else begin
         pc_exp <= PC_VALID && td[TDR_PC_EN] && ((PC ^ pa) & ~pm) == 32'h0;
         gl     <= td[TDR_GLOBAL_EN];
         if (REG_REQ.wr && REG_REQ.code == CODE_PC_ADDRESS) pa <= REG_REQ.wdata;
         if (REG_REQ.wr && REG_REQ.code == CODE_PC_MASK) pm <= REG_REQ.wdata;
         if (REG_REQ.wr && REG_REQ.code == CODE_TRIGGER_DEF) td <= REG_REQ.wdata;
      end
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   chk_read_answer: assert property (REG_REQ.rd |=> REG_RVALID)
      else $error("read not answered");
   chk_pc_rdzero: assert property (REG_REQ.rd && REG_REQ.code == CODE_PC_ADDRESS |=> REG_RDATA == 32'h0)
      else $error("write-only register read nonzero");
   chk_halt_cause: assert property ($rose(HALT) |-> $past(INSN_DONE))
      else $error("halt without retirement");
   chk_go_release: assert property (HALT && GO_CMD |=> !HALT)
      else $error("resume did not release halt");
   chk_halt_holds: assert property (HALT && !GO_CMD |=> HALT)
      else $error("halt dropped without resume");
   chk_irq_blocked: assert property (HALT |-> !IRQ_TO_CORE)
      else $error("interrupt passed while halted");
   chk_pc_compare: assert property (PC_MATCH == pc_exp)
      else $error("pc compare wrong");
   chk_trig_gate: assert property (BREAK_TRIGGER == (gl && (PC_MATCH || DATA_MATCH)))
      else $error("trigger gating wrong");

   cover property (BREAK_TRIGGER);
   cover property (HALT && GO_CMD);
   cover property (IRQ_TO_CORE);
endmodule : debug_breakpoint_compare_asserts

bind debug_breakpoint_compare debug_breakpoint_compare_asserts debug_breakpoint_compare_asserts_i (
   .CLK(CLK), .RST(RST), .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
   .PC_VALID(PC_VALID), .PC(PC), .INSN_DONE(INSN_DONE), .GO_CMD(GO_CMD), .HALT(HALT),
   .IRQ_TO_CORE(IRQ_TO_CORE), .PC_MATCH(PC_MATCH), .DATA_MATCH(DATA_MATCH), .BREAK_TRIGGER(BREAK_TRIGGER));

// ==== testbench/tb.sv ====
`timescale 1ns/100ps
module tb;
   import debug_breakpoint_pkg::*;
   logic        clk, rst, pc_valid, go, irq_req, halt, irq_ack, irq_out, insn_done;
   logic        rvalid, pc_m, d_m, trig, eh, ep;
   logic [31:0] rdata, pc, lf, r, lm, dv, dm, pa, pm, td;
   logic [3:0]  gap;
   logic [4:0]  codes [7] = '{5'h00, 5'h07, 5'h08, 5'h09, 5'h0e, 5'h0f, 5'h1f};
   reg_req_t    req;
   data_ref_t   dref;
   int          n_mismatch, total_checks, n, li;

   debug_breakpoint_compare debug_breakpoint_compare_i (.CLK(clk), .RST(rst), .CE(1'b1), .REG_REQ(req),
      .REG_RDATA(rdata), .REG_RVALID(rvalid), .PC_VALID(pc_valid), .PC(pc), .DATA_REF(dref),
      .INSN_DONE(insn_done), .GO_CMD(go), .HALT(halt), .IRQ_REQ(irq_req), .IRQ_ACK(irq_ack),
      .IRQ_TO_CORE(irq_out), .PC_MATCH(pc_m), .DATA_MATCH(d_m), .BREAK_TRIGGER(trig));
   core_model core_model_i (.clk(clk), .rst(rst), .gap(gap), .halt(halt), .irq(irq_out),
      .insn_done(insn_done), .irq_ack(irq_ack));

   // Free-running 25 MHz clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Pseudo-random source, fixed start so runs repeat
   function automatic logic [31:0] nx();
      lf = {lf[30:0], 1'b0} ^ (lf[31] ? 32'h04c11db7 : 32'h0);
      return lf;
   endfunction : nx

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : final_report

   // Register write launched at the falling edge; the strobe stays up until the
   // caller starts another transfer or goes idle, so req changes once per step
   task automatic wr(input logic [4:0] c, input logic [31:0] d);
      req = '{1'b1, 1'b0, c, d};
      @(negedge clk);
   endtask : wr

   // Register read: answer stands for the single cycle after the read edge
   task automatic rd(input logic [4:0] c, input logic [31:0] exp);
      req = '{1'b0, 1'b1, c, nx()};
      @(negedge clk);
      chk(rvalid, 1);
      chk(rdata, exp);
   endtask : rd

   task automatic pulse_go;
      req = '0;
      go = 1'b1;
      @(negedge clk);
      go = 1'b0;
   endtask : pulse_go

   // Bounded wait for a step halt; a hang ends the run
   task automatic wait_halt;
      req = '0;
      for (int t = 0; t < 40 && halt !== 1'b1; t++) @(negedge clk);
      chk(halt, 1);
      if (halt !== 1'b1) final_report();
   endtask : wait_halt

   // Interrupt raised while halted in step mode, then stepping left and resumed
   task automatic irq_case(input logic ign, input logic exp);
      wr(CODE_CONFIG_STATUS, {26'h0, ign, 5'h10});
      wait_halt();
      irq_req = 1'b1;
      @(negedge clk);
      irq_req = 1'b0;
      wr(CODE_CONFIG_STATUS, {26'h0, ign, 5'h00});
      pulse_go();
      eh = 1'b0;
      repeat (12) @(negedge clk) eh |= irq_out;
      chk(eh, exp);
   endtask : irq_case

   initial begin
      #(40 * 20000);
      n_mismatch++;
      final_report();
   end

   initial begin
      {rst, pc_valid, go, irq_req} = 4'h8;
      {pc, dv, dm, pa, pm, td} = 192'h0;
      req = '0;
      dref = '0;
      gap = 4'h3;
      lf = 32'h2ddd18cd;
      n_mismatch = 0;
      total_checks = 0;
      repeat (6) @(negedge clk);
      rst = 1'b0;
      foreach (codes[i]) rd(codes[i], 32'h0);
      for (int i = 0; i < 9; i++) begin
         r = nx();
         wr(codes[3 + i % 3], r);
         rd(codes[3 + i % 3], r);
      end
      wr(CODE_PC_ADDRESS, nx());
      rd(CODE_PC_ADDRESS, 32'h0);
      // Random lanes, masks and near-hits; every eighth pass clears all lane enables
      for (int i = 0; i < 64; i++) begin
         td = nx() & ((i % 8 == 7) ? 32'hffffe03f : 32'hffffffff);
         dv = nx();
         dm = nx() | nx();
         pa = nx();
         pm = nx() | nx();
         wr(CODE_DATA_VALUE, dv);
         wr(CODE_DATA_MASK, dm);
         wr(CODE_PC_ADDRESS, pa);
         wr(CODE_PC_MASK, pm);
         wr(CODE_TRIGGER_DEF, td);
         req = '0;
         r = nx();
         dref = '{1'b1, i[1:0], r[1:0], i[2] ? dv ^ (nx() & dm) : nx()};
         pc_valid = r[2];
         pc = i[3] ? pa ^ (nx() & pm) : nx();
         lm = dref.size == 2'h0 ? 32'hff000000 >> (8 * dref.addr_lo) :
              dref.size == 2'h1 ? (dref.addr_lo[1] ? 32'h0000ffff : 32'hffff0000) : 32'hffffffff;
         li = dref.size == 2'h0 ? 6 + dref.addr_lo : dref.size == 2'h1 ? 10 + dref.addr_lo[1] : 12;
         eh = dref.size != 2'h3 && td[li] && ((dref.data ^ dv) & ~dm & lm) == 32'h0;
         ep = pc_valid && td[1] && ((pc ^ pa) & ~pm) == 32'h0;
         @(negedge clk);
         dref.valid = 1'b0;
         pc_valid = 1'b0;
         chk(d_m, eh);
         chk(pc_m, ep);
         chk(trig, td[13] && (eh || ep));
      end
      // Single stepping with a slow or prompt core
      wr(CODE_TRIGGER_DEF, 32'h0);
      wr(CODE_CONFIG_STATUS, 32'h10);
      wait_halt();
      for (int k = 0; k < 3; k++) begin
         rd(CODE_CONFIG_STATUS, 32'h02000010);
         r = nx();
         gap = {2'h0, r[1:0]} + 4'h2;
         pulse_go();
         n = 0;
         for (int t = 0; t < 40 && halt !== 1'b1; t++) begin
            @(negedge clk);
            n += insn_done;
         end
         chk(n, 1);
         chk(halt, 1);
      end
      wr(CODE_CONFIG_STATUS, 32'h0);
      pulse_go();
      irq_case(1'b1, 1'b0);
      irq_case(1'b0, 1'b1);
      final_report();
   end
endmodule : tb
